// ### sppc_pkg.sv
// Package for the sleep power plane control block: register map, fields, states, timing
package sppc_pkg;

  // Register byte offsets
  localparam logic [7:0] SPPC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SPPC_POLICY_OFS = 8'h04;
  localparam logic [7:0] SPPC_WLAN_OFS   = 8'h08;
  localparam logic [7:0] SPPC_STATUS_OFS = 8'h0c;
  localparam logic [7:0] SPPC_GP_OFS     = 8'h10;

  // Control register fields
  localparam int CTRL_STRETCH_EN_BIT  = 3;
  localparam int CTRL_DEEPSX_SUP_BIT  = 0;
  localparam int CTRL_MGMT_WLAN_BIT   = 1;
  localparam int CTRL_MGMT_ACK_BIT    = 2;
  localparam int CTRL_MGMT_PHY_BIT    = 4;
  // Policy register fields
  localparam int POL_SLEEP_PHY_BIT    = 27;
  localparam int POL_AFTER_G3_BIT     = 28;
  localparam int POL_DEEP_PHY_DIS_BIT = 29;
  localparam int POL_BATT_PHY_DIS_BIT = 30;
  // Wireless policy field
  localparam int WLAN_WAKE_POL_BIT    = 4;
  // General purpose port fields
  localparam int GP_DIR_BIT           = 0;
  localparam int GP_DATA_BIT          = 1;
  localparam int GP_NATIVE_BIT        = 2;
  // Status register fields
  localparam int ST_SMI_BIT           = 0;
  localparam int ST_NOT_CYCLED_BIT    = 1;
  localparam int ST_AFTER_G3_BIT      = 2;

  localparam logic [31:0] SPPC_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SPPC_POLICY_RST = 32'h0000_0000;
  localparam logic [31:0] SPPC_WLAN_RST   = 32'h0000_0000;
  localparam logic [31:0] SPPC_GP_RST     = 32'h0000_0004;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Minimum memory power-off time, microseconds
  localparam int  SPPC_CLK_HZ         = 40_000_000;
  localparam int  SPPC_MIN_MEM_OFF_US = 1_000_000;
  localparam longint SPPC_MIN_MEM_OFF_CYC =
    (longint'(SPPC_MIN_MEM_OFF_US) * SPPC_CLK_HZ + 999_999) / 1_000_000;

  // Sleep state requests from the sleep-state selector
  typedef enum logic [2:0] {
    SPPC_S0      = 3'b000,
    SPPC_S3      = 3'b011,
    SPPC_S4      = 3'b100,
    SPPC_S5      = 3'b101,
    SPPC_DEEP_SX = 3'b110
  } sppc_state_t;

  // Reset kinds reported by the reset logic
  typedef enum logic [1:0] {
    SPPC_RST_NONE   = 2'b00,
    SPPC_RST_CYCLE  = 2'b01,
    SPPC_RST_GLOBAL = 2'b10,
    SPPC_RST_S5     = 2'b11
  } sppc_rst_t;

endpackage : sppc_pkg

// ### sppc_sync.sv
// Two-flop synchroniser for asynchronous input levels
`timescale 1ns/1ps
`default_nettype none
module sppc_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sppc_sync
`default_nettype wire

// ### sppc_ctrl.sv
// Sleep power plane control: rail sleep outputs, PHY power, suspend pin, AXI4-Lite registers
//
// How it works
// - Core rail sleep asserts only in S3 and deeper
// - Core-plane outputs low during S3
// - Deep rail sleep asserts in S4 and deeper
// - Stretch deep sleep and flag uncycled memory
// - Low power good resets platform asynchronously
// - Battery low blocks wake from sleep
// - Battery low in S0 raises SYSTEM_MGMT_INTERRUPT
// - Wired PHY on when core or mgmt on
// - After-G3 and sleep policies keep PHY on
// - Deep-sleep and battery policies remove PHY
// - Wireless PHY on when core on
// - Wireless wake policy keeps PHY in S3-S5
// - Mgmt wireless access follows mgmt rail
// - Ack low in S0 and mgmt-on sleep
// - Warning high, asserts on deep entry
// - Ack low during power-cycle and global reset
// - GP port: Hi-Z input or data output
// - RTC reset returns RTC registers to defaults
`timescale 1ns/1ps
`default_nettype none
module sppc_ctrl
  import sppc_pkg::*;
#(
  parameter longint MIN_MEM_OFF_CYC = SPPC_MIN_MEM_OFF_CYC,
  parameter int     CNT_W           = 26
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sleep control from the sleep-state selector
  input  wire logic [2:0]  sleep_state,
  input  wire logic        mgmt_on_state,
  input  wire logic        on_battery,
  input  wire logic        wake_request,
  input  wire logic [1:0]  reset_kind,
  input  wire logic        after_g3,
  // Pins
  input  wire logic        core_power_good,
  input  wire logic        battery_low_n,
  input  wire logic        rtc_well_reset_n,
  input  wire logic        secondary_rtc_well_reset_n,
  input  wire logic        mem_power_sense,
  input  wire logic        muxed_gp_pin_in,
  output logic             muxed_gp_pin_out,
  output logic             muxed_gp_pin_oe,
  output logic             core_rail_sleep_n,
  output logic             deep_rail_sleep_n,
  output logic             soft_off_sleep_n,
  output logic             mgmt_rail_sleep_n,
  output logic             wired_phy_power_n,
  output logic             wireless_phy_power_n,
  output logic             platform_reset_n,
  output logic             core_plane_en,
  output logic             wake_allowed,
  output logic             system_mgmt_interrupt
);
  if (CNT_W < 2 || MIN_MEM_OFF_CYC < 1
      || MIN_MEM_OFF_CYC >= (longint'(1) << CNT_W)) begin : g_cnt_chk
    $error("sppc_ctrl: counter too narrow for minimum memory off time");
  end

  function automatic logic [31:0] merge_wr(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_wr

  // Asynchronous pins synchronised
  logic batt_low_s;
  logic rtc_rst_s;
  logic mem_sense_s;
  logic pwr_good_s;
  logic gp_in_s;

  sppc_sync #(.WIDTH(5), .INIT(5'h0)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({~battery_low_n, ~(rtc_well_reset_n & secondary_rtc_well_reset_n),
               mem_power_sense, core_power_good, muxed_gp_pin_in}),
    .q       ({batt_low_s, rtc_rst_s, mem_sense_s, pwr_good_s, gp_in_s})
  );

  // Power good low forces platform reset with no clock involved
  assign platform_reset_n = core_power_good & pwr_good_s;

  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] policy_reg;
  logic [31:0] wlan_reg;
  logic [31:0] gp_reg;
  logic        smi_sts;
  logic        not_cycled_sts;
  logic        after_g3_sts;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  logic wr_hit;
  always_comb begin
    unique case (aw_addr)
      SPPC_CTRL_OFS, SPPC_POLICY_OFS, SPPC_WLAN_OFS, SPPC_STATUS_OFS, SPPC_GP_OFS:
        wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration lives in the RTC well; its reset returns it to the reset values
  always_ff @(posedge aclk) begin
    if (!aresetn || rtc_rst_s) begin
      ctrl_reg   <= SPPC_CTRL_RST;
      policy_reg <= SPPC_POLICY_RST;
      wlan_reg   <= SPPC_WLAN_RST;
      gp_reg     <= SPPC_GP_RST;
    end else if (wr_go) begin
      unique case (aw_addr)
        SPPC_CTRL_OFS:   ctrl_reg   <= merge_wr(ctrl_reg, w_data, w_strb);
        SPPC_POLICY_OFS: policy_reg <= merge_wr(policy_reg, w_data, w_strb);
        SPPC_WLAN_OFS:   wlan_reg   <= merge_wr(wlan_reg, w_data, w_strb);
        SPPC_GP_OFS:     gp_reg     <= merge_wr(gp_reg, w_data, w_strb);
        default: ;
      endcase
    end
  end

  logic        status_clr_wr;
  logic [31:0] status_clr;
  assign status_clr_wr = wr_go && (aw_addr == SPPC_STATUS_OFS);
  assign status_clr    = status_clr_wr ? (w_data & {{8{w_strb[3]}}, {8{w_strb[2]}},
                                                    {8{w_strb[1]}}, {8{w_strb[0]}}})
                                       : 32'h0000_0000;

  // Sleep state decode
  logic in_s0;
  logic in_sx;
  logic in_deep;
  logic state_s4_up;
  assign in_s0       = (sleep_state == SPPC_S0);
  assign in_deep     = (sleep_state == SPPC_DEEP_SX);
  assign in_sx       = (sleep_state == SPPC_S3) || (sleep_state == SPPC_S4)
                    || (sleep_state == SPPC_S5);
  assign state_s4_up = (sleep_state == SPPC_S4) || (sleep_state == SPPC_S5) || in_deep;

  // SYSTEM_MGMT_INTERRUPT on battery low while running; set wins over a software clear
  logic batt_low_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      batt_low_d <= 1'b0;
      smi_sts    <= 1'b0;
    end else begin
      batt_low_d <= batt_low_s;
      if (batt_low_s && !batt_low_d && in_s0) smi_sts <= 1'b1;
      else if (status_clr[ST_SMI_BIT]) smi_sts <= 1'b0;
    end
  end
  assign system_mgmt_interrupt = smi_sts;

  assign wake_allowed = wake_request && !((in_sx || in_deep) && batt_low_s);

  // Deep rail stretch: memory stays off a minimum time once off
  logic [CNT_W-1:0] off_cnt;
  logic             stretching;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_cnt        <= '0;
      stretching     <= 1'b0;
      not_cycled_sts <= 1'b0;
    end else begin
      if (state_s4_up) begin
        stretching <= ctrl_reg[CTRL_STRETCH_EN_BIT];
        if (off_cnt != CNT_W'(MIN_MEM_OFF_CYC)) off_cnt <= off_cnt + 1'b1;
      end else if (stretching && off_cnt != CNT_W'(MIN_MEM_OFF_CYC)) begin
        off_cnt <= off_cnt + 1'b1;
      end else begin
        stretching <= 1'b0;
        off_cnt    <= '0;
      end
      // Memory still powered after the minimum off time: not cycled
      if (stretching && off_cnt == CNT_W'(MIN_MEM_OFF_CYC) - 1'b1 && mem_sense_s)
        not_cycled_sts <= 1'b1;
      else if (status_clr[ST_NOT_CYCLED_BIT]) not_cycled_sts <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) after_g3_sts <= 1'b1;
    else if (after_g3) after_g3_sts <= 1'b1;
    else if (status_clr[ST_AFTER_G3_BIT]) after_g3_sts <= 1'b0;
  end

  // Wired PHY policy
  logic wired_keep;
  always_comb begin
    wired_keep = 1'b0;
    if (in_sx) wired_keep = policy_reg[POL_SLEEP_PHY_BIT] || ctrl_reg[CTRL_MGMT_PHY_BIT];
    if (in_deep) wired_keep = !policy_reg[POL_DEEP_PHY_DIS_BIT];
    if (after_g3_sts && policy_reg[POL_AFTER_G3_BIT]) wired_keep = 1'b1;
    if (on_battery && policy_reg[POL_BATT_PHY_DIS_BIT]) wired_keep = 1'b0;
  end

  // Rail outputs, registered, change only on state, mgmt-on state, policy, wireless policy, control register, battery, after-G3 status or stretch timer change
  logic next_core_n;
  logic next_mgmt_n;
  assign next_core_n = !(in_sx || in_deep);
  assign next_mgmt_n = !(in_deep || ((in_sx) && !mgmt_on_state));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rail_sleep_n    <= 1'b0;
      deep_rail_sleep_n    <= 1'b0;
      soft_off_sleep_n     <= 1'b0;
      mgmt_rail_sleep_n    <= 1'b0;
      wired_phy_power_n    <= 1'b0;
      wireless_phy_power_n <= 1'b0;
      core_plane_en        <= 1'b0;
    end else begin
      core_rail_sleep_n <= next_core_n;
      core_plane_en     <= next_core_n;
      deep_rail_sleep_n <= !(state_s4_up || stretching);
      soft_off_sleep_n  <= !((sleep_state == SPPC_S5) || in_deep);
      mgmt_rail_sleep_n <= next_mgmt_n;
      wired_phy_power_n <= next_core_n || next_mgmt_n || wired_keep;
      wireless_phy_power_n <= next_core_n
        || (wlan_reg[WLAN_WAKE_POL_BIT] && in_sx)
        || (ctrl_reg[CTRL_MGMT_WLAN_BIT] && next_mgmt_n);
    end
  end

  // Multiplexed suspend pin: ack, warning or general purpose port
  logic deep_entry_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      muxed_gp_pin_out <= 1'b0;
      muxed_gp_pin_oe  <= 1'b0;
      deep_entry_seen  <= 1'b0;
    end else begin
      deep_entry_seen <= in_deep;
      if (!gp_reg[GP_NATIVE_BIT]) begin
        muxed_gp_pin_oe  <= !gp_reg[GP_DIR_BIT] && !in_deep;
        muxed_gp_pin_out <= gp_reg[GP_DATA_BIT] && !in_deep;
      end else if (ctrl_reg[CTRL_DEEPSX_SUP_BIT]) begin
        // Warning asserts on deep entry; pin is lost once the well drops
        muxed_gp_pin_oe  <= !(in_deep && deep_entry_seen);
        muxed_gp_pin_out <= !in_deep;
      end else begin
        muxed_gp_pin_oe <= !in_deep;
        if (reset_kind == SPPC_RST_CYCLE || reset_kind == SPPC_RST_GLOBAL)
          muxed_gp_pin_out <= 1'b0;
        else if (reset_kind == SPPC_RST_S5)
          muxed_gp_pin_out <= 1'b0;
        else if (in_sx && !mgmt_on_state)
          muxed_gp_pin_out <= ctrl_reg[CTRL_MGMT_ACK_BIT];
        else
          muxed_gp_pin_out <= 1'b0;
      end
    end
  end

  // Read channel
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      SPPC_CTRL_OFS:   rd_val = ctrl_reg;
      SPPC_POLICY_OFS: rd_val = policy_reg;
      SPPC_WLAN_OFS:   rd_val = wlan_reg;
      SPPC_STATUS_OFS: begin
        rd_val[ST_SMI_BIT]        = smi_sts;
        rd_val[ST_NOT_CYCLED_BIT] = not_cycled_sts;
        rd_val[ST_AFTER_G3_BIT]   = after_g3_sts;
      end
      SPPC_GP_OFS: begin
        rd_val = gp_reg;
        rd_val[GP_DATA_BIT] = gp_reg[GP_DIR_BIT] ? gp_in_s : gp_reg[GP_DATA_BIT];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : sppc_ctrl
`default_nettype wire

// ### sppc_ctrl_assertions.sv
// Checker for the sleep power plane outputs
`timescale 1ns/1ps
`default_nettype none
module sppc_ctrl_assertions
  import sppc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [2:0] sleep_state,
  input wire logic       battery_low_n,
  input wire logic       core_power_good,
  input wire logic       core_rail_sleep_n,
  input wire logic       deep_rail_sleep_n,
  input wire logic       mgmt_rail_sleep_n,
  input wire logic       wired_phy_power_n,
  input wire logic       wireless_phy_power_n,
  input wire logic       platform_reset_n,
  input wire logic       core_plane_en,
  input wire logic       wake_allowed,
  input wire logic       system_mgmt_interrupt,
  input wire logic       muxed_gp_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_core_only_s3;
    aresetn |=> core_rail_sleep_n == ($past(sleep_state) == SPPC_S0);
  endproperty
  a_core_only_s3: assert property (p_core_only_s3)
    else $error("core rail sleep does not follow the state");
  property p_plane_off;
    sleep_state != SPPC_S0 |=> !core_plane_en;
  endproperty
  a_plane_off: assert property (p_plane_off)
    else $error("core plane outputs on while core rail off");
  property p_deep_rail;
    sleep_state inside {SPPC_S4, SPPC_S5, SPPC_DEEP_SX} |=> !deep_rail_sleep_n;
  endproperty
  a_deep_rail: assert property (p_deep_rail)
    else $error("deep rail not asserted in deep states");
  property p_pg_reset;
    !core_power_good |-> !platform_reset_n;
  endproperty
  a_pg_reset: assert property (p_pg_reset)
    else $error("platform reset released while power good low");
  property p_wake_block;
    (!battery_low_n && sleep_state != SPPC_S0) [*4] |-> !wake_allowed;
  endproperty
  a_wake_block: assert property (p_wake_block)
    else $error("wake allowed with battery low in sleep");
  property p_smi;
    (!battery_low_n && sleep_state == SPPC_S0) [*5] |-> system_mgmt_interrupt;
  endproperty
  a_smi: assert property (p_smi)
    else $error("no interrupt on battery low while running");
  property p_wired_on;
    core_rail_sleep_n || mgmt_rail_sleep_n |-> wired_phy_power_n;
  endproperty
  a_wired_on: assert property (p_wired_on)
    else $error("wired phy off while core or mgmt rail on");
  property p_wless_on;
    core_rail_sleep_n |-> wireless_phy_power_n;
  endproperty
  a_wless_on: assert property (p_wless_on)
    else $error("wireless phy off while core rail on");
  property p_pin_off_deep;
    // Warning mode drives one entry cycle before letting go
    sleep_state == SPPC_DEEP_SX [*2] |=> !muxed_gp_pin_oe;
  endproperty
  a_pin_off_deep: assert property (p_pin_off_deep)
    else $error("multiplexed pin driven in deep sleep");
endmodule : sppc_ctrl_assertions

bind sppc_ctrl sppc_ctrl_assertions u_sppc_chk (
  .aclk, .aresetn, .sleep_state, .battery_low_n, .core_power_good, .core_rail_sleep_n,
  .deep_rail_sleep_n, .mgmt_rail_sleep_n, .wired_phy_power_n, .wireless_phy_power_n,
  .platform_reset_n, .core_plane_en, .wake_allowed, .system_mgmt_interrupt, .muxed_gp_pin_oe
);
`default_nettype wire

// ### sppc_platform_model.sv
// Platform supplies: power good, memory rail sense, RTC resets, pin
`timescale 1ns/1ps
`default_nettype none
module sppc_platform_model #(
  parameter int PG_DELAY = 8
) (
  input  wire logic aclk,
  input  wire logic core_rail_sleep_n,
  input  wire logic deep_rail_sleep_n,
  input  wire logic muxed_gp_pin_out,
  input  wire logic muxed_gp_pin_oe,
  input  wire logic pf_fail,
  input  wire logic mem_slow,
  input  wire logic in_g3,
  output logic      core_power_good,
  output logic      mem_power_sense,
  output logic      rtc_well_reset_n,
  output logic      secondary_rtc_well_reset_n,
  output logic      muxed_gp_pin_in
);
  int   pg_cnt = 0;
  int   mem_cnt = 0;
  logic last_pin = 1'b0;
  // Good only after the rail held steady; a counter compare cannot glitch
  always_ff @(posedge aclk) begin
    if (!core_rail_sleep_n || pf_fail) begin
      pg_cnt <= 0;
    end else if (pg_cnt < PG_DELAY) begin
      pg_cnt <= pg_cnt + 1;
    end
  end
  assign core_power_good = (pg_cnt == PG_DELAY);
  always_ff @(posedge aclk) begin
    if (deep_rail_sleep_n) begin
      mem_cnt <= 0;
    end else if (mem_cnt < 100) begin
      mem_cnt <= mem_cnt + 1;
    end
  end
  // Slow decay leaves memory powered past the stretch
  assign mem_power_sense            = mem_cnt < (mem_slow ? 60 : 2);
  assign rtc_well_reset_n           = !in_g3;
  assign secondary_rtc_well_reset_n = !in_g3;
  // No pull on the pin: undriven shows the inverse of the last driven level
  always_ff @(posedge aclk) begin
    if (muxed_gp_pin_oe) last_pin <= muxed_gp_pin_out;
  end
  assign muxed_gp_pin_in = muxed_gp_pin_oe ? muxed_gp_pin_out : !last_pin;
endmodule : sppc_platform_model
`default_nettype wire

// ### tb.sv
// Testbench for the sleep power plane control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sppc_pkg::*;
  typedef struct packed {logic [2:0] s; logic m; logic [6:0] e;} sppc_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, mgmt_on_state, on_battery, wake_request, after_g3;
  logic        core_power_good, battery_low_n, rtc_well_reset_n, secondary_rtc_well_reset_n;
  logic        mem_power_sense, muxed_gp_pin_in, muxed_gp_pin_out, muxed_gp_pin_oe;
  logic        core_rail_sleep_n, deep_rail_sleep_n, soft_off_sleep_n, mgmt_rail_sleep_n;
  logic        wired_phy_power_n, wireless_phy_power_n, platform_reset_n, core_plane_en;
  logic        wake_allowed, system_mgmt_interrupt, pf_fail, mem_slow, in_g3;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reset_kind, rs;
  logic [2:0]  sleep_state;
  int          fail_count, check_count;
  logic [7:0]  ofs [6] = '{SPPC_CTRL_OFS, SPPC_POLICY_OFS, SPPC_WLAN_OFS, SPPC_STATUS_OFS,
                           SPPC_GP_OFS, 8'h20};
  logic [31:0] rstv [6] = '{SPPC_CTRL_RST, SPPC_POLICY_RST, SPPC_WLAN_RST, 32'h0000_0004,
                            SPPC_GP_RST, 32'h0000_0000};
  // Expected: core, deep, mgmt, plane, wireless, pin oe, pin level
  sppc_row_t   rows [6] = '{'{SPPC_S0, 1'b0, 7'h7e}, '{SPPC_S3, 1'b0, 7'h22},
                            '{SPPC_S3, 1'b1, 7'h32}, '{SPPC_S4, 1'b0, 7'h02},
                            '{SPPC_S5, 1'b0, 7'h02}, '{SPPC_DEEP_SX, 1'b0, 7'h00}};

  sppc_ctrl #(.MIN_MEM_OFF_CYC(20)) uut (.*);
  sppc_platform_model pm (.*);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic nap(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : nap

  // Holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int   n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      wrap_up();
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    logic ha, hr;
    int   n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      wrap_up();
    end
  endtask : rdr

  task automatic put_state(input logic [2:0] s, input logic m);
    @(posedge aclk);
    sleep_state   <= s;
    mgmt_on_state <= m;
    nap(3);
  endtask : put_state

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {mgmt_on_state, on_battery, wake_request, after_g3, pf_fail, mem_slow, in_g3} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, reset_kind} = '0;
    s_axi_wstrb   = 4'hf;
    battery_low_n = 1'b1;
    sleep_state   = SPPC_S0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    nap(2);
    for (int i = 0; i < 6; i++) begin
      rdr(ofs[i]);
      chk(rd, rstv[i]);
      chk(rs, (i == 5) ? AXI_SLVERR : AXI_OKAY);
    end
    wr(8'h20, 32'hffff_ffff);
    chk(rs, AXI_SLVERR);
    $display("registers done");
    foreach (rows[i]) begin
      put_state(rows[i].s, rows[i].m);
      chk({core_rail_sleep_n, deep_rail_sleep_n, mgmt_rail_sleep_n, core_plane_en,
           wireless_phy_power_n, muxed_gp_pin_oe, muxed_gp_pin_oe & muxed_gp_pin_out},
          rows[i].e);
      chk(soft_off_sleep_n, !(rows[i].s inside {SPPC_S5, SPPC_DEEP_SX}));
    end
    $display("state table done");
    put_state(SPPC_S0, 1'b0);
    @(posedge aclk);
    battery_low_n <= 1'b0;
    wake_request  <= 1'b1;
    nap(5);
    chk(system_mgmt_interrupt, 1'b1);
    chk(wake_allowed, 1'b1);
    put_state(SPPC_S3, 1'b0);
    chk(wake_allowed, 1'b0);
    @(posedge aclk);
    battery_low_n <= 1'b1;
    nap(4);
    chk(wake_allowed, 1'b1);
    wr(SPPC_STATUS_OFS, 32'h1);
    nap(2);
    chk(system_mgmt_interrupt, 1'b0);
    $display("battery done");
    wr(SPPC_POLICY_OFS, 32'h0800_0000);
    nap(3);
    chk(wired_phy_power_n, 1'b1);
    @(posedge aclk);
    on_battery <= 1'b1;
    wr(SPPC_POLICY_OFS, 32'h4800_0000);
    nap(3);
    chk(wired_phy_power_n, 1'b0);
    @(posedge aclk);
    on_battery <= 1'b0;
    wr(SPPC_WLAN_OFS, 32'h10);
    nap(3);
    chk(wireless_phy_power_n, 1'b1);
    wr(SPPC_WLAN_OFS, 32'h0);
    wr(SPPC_CTRL_OFS, 32'h2);
    put_state(SPPC_S3, 1'b1);
    chk(wireless_phy_power_n, 1'b1);
    $display("phy policy done");
    wr(SPPC_CTRL_OFS, 32'h4);
    put_state(SPPC_S3, 1'b0);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b11);
    for (int k = 1; k < 4; k++) begin
      @(posedge aclk);
      reset_kind <= k[1:0];
      nap(3);
      chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b10);
    end
    @(posedge aclk);
    reset_kind <= 2'b00;
    nap(3);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b11);
    wr(SPPC_CTRL_OFS, 32'h1);
    nap(3);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b11);
    put_state(SPPC_DEEP_SX, 1'b0);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b00);
    put_state(SPPC_S0, 1'b0);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b11);
    wr(SPPC_GP_OFS, 32'h1);
    nap(3);
    chk(muxed_gp_pin_oe, 1'b0);
    wr(SPPC_GP_OFS, 32'h2);
    nap(3);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b11);
    wr(SPPC_GP_OFS, 32'h0);
    nap(3);
    chk({muxed_gp_pin_oe, muxed_gp_pin_out}, 2'b10);
    $display("pin done");
    wr(SPPC_CTRL_OFS, 32'h8);
    for (int j = 0; j < 2; j++) begin
      mem_slow <= j[0];
      put_state(SPPC_S4, 1'b0);
      put_state(SPPC_S0, 1'b0);
      nap(5);
      chk(deep_rail_sleep_n, 1'b0);
      nap(60);
      chk(deep_rail_sleep_n, 1'b1);
      rdr(SPPC_STATUS_OFS);
      chk(rd[ST_NOT_CYCLED_BIT], j[0]);
    end
    $display("stretch done");
    wr(SPPC_POLICY_OFS, 32'h4000_0000);
    in_g3 <= 1'b1;
    nap(4);
    @(posedge aclk);
    in_g3 <= 1'b0;
    nap(4);
    rdr(SPPC_POLICY_OFS);
    chk(rd, SPPC_POLICY_RST);
    chk(platform_reset_n, 1'b1);
    @(posedge aclk);
    pf_fail <= 1'b1;
    nap(2);
    chk({core_power_good, platform_reset_n}, 2'b00);
    $display("rtc and power good done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
